// [ddrpi_pkg.sv]
// Functional notes
// R1: write strobe edges are launched half a link clock after the data, in the middle of the data and check-bit window.
// R2: the DRAM returns read strobes edge aligned with data, so the controller samples read data half a link clock late.
// R3: eighteen strobe pairs exist; all eighteen are active for x4 devices and only nine for x8 devices.
// R4: an eight-bit check code goes out with every written beat and is captured with every read beat.
// R5: the sixteen-bit address bus carries row and column addresses and the mode register value for mode register loads.
// R6: a parity bit with each command makes address, bank, command lines and the bit hold an odd count of ones.
// R7: each registered DIMM reports parity errors on its own active-low line; one input per DIMM is watched.
// R8: four termination enables are driven during reads and writes to pick target and non-target termination.
// R9: the active-low DRAM reset is low at power-up, high in self refresh, otherwise follows a configuration bit.
// R10: all command and control pins change on the rising link clock edge so DIMMs sample them there.
// R11: exactly one of eight active-low chip selects is asserted with each command to choose the rank.
// R12: a three-bit bank address goes with every activate, read, write and precharge.
// R13: row strobe, column strobe and write enable follow the standard DDR3 command truth table.
package ddrpi_pkg;
	localparam int DQ_W = 64;
	localparam int ECC_W = 8;
	localparam int DQS_W = 18;
	localparam int DQS_X8 = 9;
	localparam int ADDR_W = 16;
	localparam int BANK_W = 3;
	localparam int RANK_W = 3;
	localparam int CS_W = 8;
	localparam int ODT_W = 4;
	localparam int DIMM_N = 3;
	localparam int BUF_DEPTH = 2;
	localparam int READ_LAT_DEF = 5;
	localparam int LAT_W = 8;
	localparam logic [DQS_W-1:0] DQS_ALL = 18'h3_FFFF;
	localparam logic [DQS_W-1:0] DQS_HALF = 18'h0_01FF;
	localparam logic [CS_W-1:0] CS_NONE = 8'hFF;

	// codes are {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		CMD_MRS = 3'b000,
		CMD_REF = 3'b001,
		CMD_PRE = 3'b010,
		CMD_ACT = 3'b011,
		CMD_WR = 3'b100,
		CMD_RD = 3'b101,
		CMD_ZQ = 3'b110,
		CMD_NOP = 3'b111
	} ddrpi_cmd_e;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_WR = 2'b01,
		L_RD = 2'b10
	} ddrpi_state_e;

	typedef struct packed {
		ddrpi_cmd_e cmd;
		logic [RANK_W-1:0] rank;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [ODT_W-1:0] odt;
		logic [DQ_W-1:0] wdata;
		logic [ECC_W-1:0] wecc;
	} ddrpi_req_s;

	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [ECC_W-1:0] ecc;
	} ddrpi_rd_s;
endpackage : ddrpi_pkg

// [ddrpi_channel.sv]
module ddrpi_channel #(
	parameter int READ_LAT = ddrpi_pkg::READ_LAT_DEF,
	parameter int DEPTH = ddrpi_pkg::BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire ddrpi_pkg::ddrpi_req_s req,
	output logic req_ready,
	output logic rd_valid,
	output ddrpi_pkg::ddrpi_rd_s rd_word,
	input wire logic x4_mode,
	input wire logic self_refresh,
	input wire logic dram_reset_cfg,
	input wire logic [ddrpi_pkg::DIMM_N-1:0] dimm_parity_error_n,
	input wire logic [ddrpi_pkg::DIMM_N-1:0] parity_err_clear,
	output logic [ddrpi_pkg::DIMM_N-1:0] parity_err_flag,
	output logic dram_reset_n,
	input wire logic mem_clk,
	output logic [ddrpi_pkg::CS_W-1:0] cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [ddrpi_pkg::BANK_W-1:0] ba,
	output logic [ddrpi_pkg::ADDR_W-1:0] mem_addr_bus,
	output logic addr_cmd_parity_out,
	output logic [ddrpi_pkg::ODT_W-1:0] odt,
	output logic [ddrpi_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [ddrpi_pkg::DQ_W-1:0] dq_in,
	output logic [ddrpi_pkg::ECC_W-1:0] ecc_out,
	output logic ecc_oe,
	input wire logic [ddrpi_pkg::ECC_W-1:0] ecc_in,
	output logic [ddrpi_pkg::DQS_W-1:0] dqs_out,
	output logic [ddrpi_pkg::DQS_W-1:0] dqs_oe,
	input wire logic [ddrpi_pkg::DQS_W-1:0] dqs_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	function automatic logic [ddrpi_pkg::CS_W-1:0] rank_sel(
		input logic [ddrpi_pkg::RANK_W-1:0] r
	);
		logic [ddrpi_pkg::CS_W-1:0] v;
		v = ddrpi_pkg::CS_NONE;
		v[r] = 1'b0;
		return v;
	endfunction : rank_sel

	function automatic logic odd_par(
		input logic [ddrpi_pkg::ADDR_W-1:0] a,
		input logic [ddrpi_pkg::BANK_W-1:0] b,
		input logic [2:0] c
	);
		return ~(^{a, b, c});
	endfunction : odd_par

	// ---------------- core clock: two-entry buffer ----------------
	ddrpi_pkg::ddrpi_req_s mem [DEPTH];
	logic [PW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [PW:0] count, next_count;
	logic next_req_ready;
	ddrpi_pkg::ddrpi_req_s hold, next_hold;
	logic req_tgl, next_req_tgl;
	logic ack_tgl, ak1, ak2;
	logic push, pop, busy;

	always_comb begin
		busy = req_tgl != ak2;
		push = req_valid && req_ready;
		pop = (count != '0) && !busy;
		next_wptr = push ? PW'(wptr + 1'b1) : wptr;
		next_rptr = pop ? PW'(rptr + 1'b1) : rptr;
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		// stalls while the crossing is busy, so the buffer really fills
		next_req_ready = next_count < (PW + 1)'(DEPTH);
		next_hold = pop ? mem[rptr] : hold;
		next_req_tgl = pop ? ~req_tgl : req_tgl;
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr] <= req;
		end
		if (rst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			req_ready <= 1'b0;
			req_tgl <= 1'b0;
			hold <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			req_ready <= next_req_ready;
			req_tgl <= next_req_tgl;
			hold <= next_hold;
		end
	end

	// ---------------- core clock: returns, parity, reset pin ----------------
	logic rt1, rt2, rt3;
	logic [ddrpi_pkg::DIMM_N-1:0] pe1, pe2;
	logic rd_tgl;
	ddrpi_pkg::ddrpi_rd_s rd_hold;
	logic next_rd_valid, next_dram_reset_n;
	ddrpi_pkg::ddrpi_rd_s next_rd_word;
	logic [ddrpi_pkg::DIMM_N-1:0] next_parity_err_flag;

	always_comb begin
		next_rd_valid = rt2 != rt3;
		// rd_hold is stable for many cycles after the toggle
		next_rd_word = next_rd_valid ? rd_hold : rd_word;
		// set wins over clear
		next_parity_err_flag = (parity_err_flag & ~parity_err_clear)
			| ~pe2; // R7
		next_dram_reset_n = self_refresh ? 1'b1 : dram_reset_cfg; // R9
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ak1 <= 1'b0;
			ak2 <= 1'b0;
			rt1 <= 1'b0;
			rt2 <= 1'b0;
			rt3 <= 1'b0;
			pe1 <= '1;
			pe2 <= '1;
			rd_valid <= 1'b0;
			rd_word <= '0;
			parity_err_flag <= '0;
			dram_reset_n <= 1'b0; // R9
		end else begin
			ak1 <= ack_tgl;
			ak2 <= ak1;
			rt1 <= rd_tgl;
			rt2 <= rt1;
			rt3 <= rt2;
			pe1 <= dimm_parity_error_n;
			pe2 <= pe1;
			rd_valid <= next_rd_valid;
			rd_word <= next_rd_word;
			parity_err_flag <= next_parity_err_flag;
			dram_reset_n <= next_dram_reset_n;
		end
	end

	// ---------------- link clock: command and data pins ----------------
	logic rm1, rm2;
	logic rq1, rq2;
	logic xm1, xm2;
	logic next_ack_tgl, next_rd_tgl;
	ddrpi_pkg::ddrpi_state_e state, next_state;
	logic [ddrpi_pkg::LAT_W-1:0] lat, next_lat;
	ddrpi_pkg::ddrpi_rd_s cap, next_rd_hold;
	logic [ddrpi_pkg::CS_W-1:0] next_cs_n;
	logic [2:0] next_cmd;
	logic [ddrpi_pkg::BANK_W-1:0] next_ba;
	logic [ddrpi_pkg::ADDR_W-1:0] next_addr;
	logic [ddrpi_pkg::ODT_W-1:0] next_odt;
	logic [ddrpi_pkg::DQ_W-1:0] next_dq;
	logic [ddrpi_pkg::ECC_W-1:0] next_ecc;
	logic next_dq_oe;
	logic take;

	// link reset is the core reset passed through two link flops
	always_ff @(posedge mem_clk) begin
		rm1 <= rst;
		rm2 <= rm1;
	end

	always_comb begin
		// level compare: a request seen mid-burst waits instead of being lost
		take = (state == ddrpi_pkg::L_IDLE) && (rq2 != ack_tgl);
		next_state = state;
		next_ack_tgl = ack_tgl;
		next_rd_tgl = rd_tgl;
		next_rd_hold = rd_hold;
		next_lat = '0;
		next_cs_n = ddrpi_pkg::CS_NONE;
		next_cmd = ddrpi_pkg::CMD_NOP;
		next_ba = ba;
		next_addr = mem_addr_bus;
		next_odt = '0;
		next_dq = dq_out;
		next_ecc = ecc_out;
		next_dq_oe = 1'b0;
		unique case (state)
			ddrpi_pkg::L_IDLE: begin
				if (take) begin
					// a write still reads hold next cycle, so its ack waits
					next_ack_tgl = (hold.cmd == ddrpi_pkg::CMD_WR) ?
						ack_tgl : ~ack_tgl;
					next_cmd = hold.cmd; // R13
					next_ba = hold.bank; // R12
					next_addr = hold.addr; // R5
					if (hold.cmd != ddrpi_pkg::CMD_NOP) begin
						next_cs_n = rank_sel(hold.rank); // R11
					end
					if (hold.cmd == ddrpi_pkg::CMD_WR) begin
						next_state = ddrpi_pkg::L_WR;
						next_odt = hold.odt; // R8
					end else if (hold.cmd == ddrpi_pkg::CMD_RD) begin
						next_state = ddrpi_pkg::L_RD;
						next_odt = hold.odt; // R8
					end
				end
			end
			ddrpi_pkg::L_WR: begin
				next_ack_tgl = ~ack_tgl;
				next_odt = odt; // R8
				next_dq = hold.wdata;
				next_ecc = hold.wecc; // R4
				next_dq_oe = 1'b1;
				next_state = ddrpi_pkg::L_IDLE;
			end
			ddrpi_pkg::L_RD: begin
				next_odt = odt; // R8
				next_lat = ddrpi_pkg::LAT_W'(lat + 1'b1);
				if (lat >= ddrpi_pkg::LAT_W'(READ_LAT)) begin
					next_rd_hold = cap; // R4
					next_rd_tgl = ~rd_tgl;
					next_state = ddrpi_pkg::L_IDLE;
				end
			end
			default: begin
				next_state = ddrpi_pkg::L_IDLE;
			end
		endcase
	end

	// all command pins change on the rising link edge
	always_ff @(posedge mem_clk) begin // R10
		if (rm2) begin
			rq1 <= 1'b0;
			rq2 <= 1'b0;
			xm1 <= 1'b0;
			xm2 <= 1'b0;
			state <= ddrpi_pkg::L_IDLE;
			ack_tgl <= 1'b0;
			rd_tgl <= 1'b0;
			rd_hold <= '0;
			lat <= '0;
			cs_n <= ddrpi_pkg::CS_NONE;
			{ras_n, cas_n, we_n} <= ddrpi_pkg::CMD_NOP;
			ba <= '0;
			mem_addr_bus <= '0;
			// nop code carries three ones, so idle parity is low
			addr_cmd_parity_out <= 1'b0; // R6
			odt <= '0;
			dq_out <= '0;
			ecc_out <= '0;
			dq_oe <= 1'b0;
			ecc_oe <= 1'b0;
		end else begin
			rq1 <= req_tgl;
			rq2 <= rq1;
			xm1 <= x4_mode;
			xm2 <= xm1;
			state <= next_state;
			ack_tgl <= next_ack_tgl;
			rd_tgl <= next_rd_tgl;
			rd_hold <= next_rd_hold;
			lat <= next_lat;
			cs_n <= next_cs_n;
			{ras_n, cas_n, we_n} <= next_cmd; // R13
			ba <= next_ba;
			mem_addr_bus <= next_addr;
			addr_cmd_parity_out <= odd_par(next_addr, next_ba, next_cmd); // R6
			odt <= next_odt;
			dq_out <= next_dq;
			ecc_out <= next_ecc;
			dq_oe <= next_dq_oe;
			ecc_oe <= next_dq_oe; // R4
		end
	end

	// strobe rises half a link clock after the data changes
	always_ff @(negedge mem_clk) begin
		if (rm2) begin
			dqs_out <= '0;
			dqs_oe <= '0;
		end else if (dq_oe) begin
			dqs_out <= ddrpi_pkg::DQS_ALL; // R1
			// x8 parts need only half the strobe pairs
			dqs_oe <= xm2 ? ddrpi_pkg::DQS_ALL : ddrpi_pkg::DQS_HALF; // R3
		end else begin
			dqs_out <= '0;
			dqs_oe <= '0;
		end
	end

	// read strobe is edge aligned: sample mid-eye on the falling link edge
	always_ff @(negedge mem_clk) begin
		cap <= {dq_in, ecc_in}; // R2
	end
endmodule : ddrpi_channel

// [ddrpi_channel_props.sv]
module ddrpi_channel_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_clk,
	input wire logic x4_mode,
	input wire logic self_refresh,
	input wire logic dram_reset_cfg,
	input wire logic [2:0] dimm_parity_error_n,
	input wire logic [2:0] parity_err_flag,
	input wire logic dram_reset_n,
	input wire logic [7:0] cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [15:0] mem_addr_bus,
	input wire logic addr_cmd_parity_out,
	input wire logic [3:0] odt,
	input wire logic dq_oe,
	input wire logic ecc_oe,
	input wire logic [17:0] dqs_out,
	input wire logic [17:0] dqs_oe
);
	logic [2:0] lrst;
	wire lr = rst | (|lrst);
	wire [2:0] cmd = {ras_n, cas_n, we_n};
	wire wr = cs_n != 8'hff && cmd == 3'b100;
	wire [17:0] msk = x4_mode ? 18'h3_ffff : 18'h0_01ff;
	// link side leaves reset a few link edges late
	always_ff @(posedge mem_clk) lrst <= {lrst[1:0], rst};
	property p_par;
		@(posedge mem_clk) disable iff (lr)
		addr_cmd_parity_out == ~^{mem_addr_bus, ba, cmd};
	endproperty
	a_par: assert property (p_par) else $error("parity");
	property p_cs;
		@(posedge mem_clk) disable iff (lr)
		cs_n != 8'hff |-> $onehot(~cs_n);
	endproperty
	a_cs: assert property (p_cs) else $error("select");
	property p_nop;
		@(posedge mem_clk) disable iff (lr)
		(cs_n == 8'hff) == (cmd == 3'b111);
	endproperty
	a_nop: assert property (p_nop) else $error("command");
	property p_wr;
		@(posedge mem_clk) disable iff (lr)
		wr |=> dq_oe && ecc_oe && $stable(odt) ##1 !dq_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("write beat");
	property p_dqs;
		@(posedge mem_clk) disable iff (lr)
		dq_oe |-> dqs_oe == msk && (dqs_out & msk) == msk;
	endproperty
	a_dqs: assert property (p_dqs) else $error("strobe");
	property p_rlo;
		@(posedge clk) disable iff (1'b0) rst |=> !dram_reset_n;
	endproperty
	a_rlo: assert property (p_rlo) else $error("reset low");
	property p_rfol;
		@(posedge clk) disable iff (rst)
		1'b1 |=> dram_reset_n == $past(self_refresh | dram_reset_cfg);
	endproperty
	a_rfol: assert property (p_rfol) else $error("reset pin");
	property p_flag(int i);
		@(posedge clk) disable iff (rst)
		!dimm_parity_error_n[i] [*3] |=> parity_err_flag[i];
	endproperty
	for (genvar g = 0; g < 3; g++) begin : g_flag
		a_flag: assert property (p_flag(g)) else $error("flag");
	end
	c_wr: cover property (@(posedge mem_clk) wr);
	c_x8: cover property (@(posedge mem_clk) dq_oe && !x4_mode);
	c_flag: cover property (@(posedge clk) |parity_err_flag);
endmodule : ddrpi_channel_props

bind ddrpi_channel ddrpi_channel_props u_props (.clk, .rst, .mem_clk,
	.x4_mode, .self_refresh, .dram_reset_cfg, .dimm_parity_error_n,
	.parity_err_flag, .dram_reset_n, .cs_n, .ras_n, .cas_n, .we_n, .ba,
	.mem_addr_bus, .addr_cmd_parity_out, .odt, .dq_oe, .ecc_oe, .dqs_out,
	.dqs_oe);

// [ddrpi_dimm_model.sv]
module ddrpi_dimm_model #(
	parameter int LAT = 5
) (
	input wire logic mem_clk,
	input wire logic [30:0] bus,
	input wire logic [71:0] beat,
	input wire logic [2:0] inj,
	output logic [71:0] rd,
	output logic [2:0] err_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	logic bad = 1'b0;
	initial rd = 72'h0;
	assign err_n = ~inj & {3{~bad}};
	always @(posedge mem_clk) begin
		// unknown pins before link reset must not look like an error
		bad <= (bus[30:23] != 8'hff && !(^bus[22:0])) === 1'b1;
		if (bus[30:23] != 8'hff && bus[22:20] == 3'b101) begin
			n <= LAT + 2;
			rd <= beat;
		end else if (n > 0) begin
			n <= n - 1;
			if (n == 1)
				rd <= ~beat;
		end
	end
endmodule : ddrpi_dimm_model

// [ddrpi_channel_test.sv]
module ddrpi_channel_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, mem_clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
	logic x4_mode = 1'b1, self_refresh = 1'b0, dram_reset_cfg = 1'b1;
	logic req_ready, rd_valid, dram_reset_n, ras_n, cas_n, we_n, dq_oe;
	logic addr_cmd_parity_out, ecc_oe;
	logic [2:0] parity_err_clear = 3'h0, inj = 3'h0, parity_err_flag, ba;
	logic [2:0] dimm_parity_error_n;
	logic [7:0] cs_n, ecc_out, ecc_in;
	logic [15:0] mem_addr_bus;
	logic [3:0] odt;
	logic [63:0] dq_out, dq_in;
	logic [17:0] dqs_out, dqs_oe;
	logic [71:0] beat = 72'h0;
	ddrpi_pkg::ddrpi_req_s req = '0;
	ddrpi_pkg::ddrpi_rd_s rd_word;
	int mismatches = 0, n_compared = 0;
	ddrpi_channel DUT (.clk, .rst, .req_valid, .req, .req_ready, .rd_valid,
		.rd_word, .x4_mode, .self_refresh, .dram_reset_cfg,
		.dimm_parity_error_n, .parity_err_clear, .parity_err_flag,
		.dram_reset_n, .mem_clk, .cs_n, .ras_n, .cas_n, .we_n, .ba,
		.mem_addr_bus, .addr_cmd_parity_out, .odt, .dq_out, .dq_oe, .dq_in,
		.ecc_out, .ecc_oe, .ecc_in, .dqs_out, .dqs_oe, .dqs_in(18'h0));
	ddrpi_dimm_model u_dimm (.mem_clk, .beat, .inj, .rd({dq_in, ecc_in}),
		.bus({cs_n, ras_n, cas_n, we_n, ba, mem_addr_bus, addr_cmd_parity_out}),
		.err_n(dimm_parity_error_n));
	always #4 clk = ~clk;
	initial begin
		#2;
		forever #15 mem_clk = ~mem_clk;
	end
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
	task automatic complete_run;
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic ddrpi_pkg::ddrpi_req_s mk(int c, int k);
		logic [15:0] a = 16'(16'h9249 * k + 16'h00f7);
		return '{ddrpi_pkg::ddrpi_cmd_e'(c), 3'(k), 3'(k ^ 5), a,
			c / 2 == 2 ? 4'(k + 1) : 4'h0, {4{a}}, 8'(k * 37)};
	endfunction : mk
	task automatic send(int c, int k);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= mk(c, k);
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
	endtask : send
	task automatic see(int c, int k);
		ddrpi_pkg::ddrpi_req_s r = mk(c, k);
		// pins are looked at mid-cycle, never on their launch edge
		do @(negedge mem_clk); while (cs_n === 8'hff);
		chk(cs_n, 8'(~(8'h01 << k)));
		chk({ras_n, cas_n, we_n}, r.cmd);
		chk({ba, mem_addr_bus}, {r.bank, r.addr});
		chk(addr_cmd_parity_out, ~^{r.addr, r.bank, r.cmd});
		chk(odt, r.odt);
	endtask : see
	task automatic t_cmds;
		for (int i = 0; i < 7; i++) begin
			send(i, i);
			see(i, i);
		end
	endtask : t_cmds
	task automatic t_write;
		ddrpi_pkg::ddrpi_req_s r = mk(4, 7);
		for (int x = 0; x < 2; x++) begin
			@(posedge clk);
			x4_mode <= x[0];
			send(4, 7);
			see(4, 7);
			@(negedge mem_clk);
			chk({dq_oe, ecc_oe, dq_out, ecc_out}, {2'b11, r.wdata, r.wecc});
			@(posedge mem_clk);
			chk({dqs_oe, dqs_out & dqs_oe}, {2{x ? 18'h3_ffff : 18'h0_01ff}});
		end
	endtask : t_write
	task automatic t_read;
		@(posedge clk);
		beat <= 72'h5a_5a0f_0f12_3487_65c3;
		send(5, 2);
		see(5, 2);
		do @(posedge clk); while (rd_valid !== 1'b1);
		chk(rd_word, beat);
	endtask : t_read
	task automatic t_fill;
		int k = 0;
		int lo = 0;
		fork
			begin
				@(posedge clk);
				req_valid <= 1'b1;
				req <= mk(3, 0);
				while (k < 4) begin
					@(posedge clk);
					if (req_ready === 1'b1)
						req <= mk(3, ++k);
					else
						lo++;
				end
				req_valid <= 1'b0;
			end
			for (int j = 0; j < 4; j++)
				see(3, j);
		join
		chk(lo != 0, 1'b1);
	endtask : t_fill
	task automatic t_perr;
		@(posedge clk);
		inj <= 3'b010;
		repeat (4) @(posedge clk);
		inj <= 3'h0;
		repeat (3) @(posedge clk);
		chk(parity_err_flag, 3'b010);
		parity_err_clear <= 3'b111;
		@(posedge clk);
		parity_err_clear <= 3'h0;
		repeat (2) @(posedge clk);
		chk(parity_err_flag, 3'h0);
	endtask : t_perr
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{self_refresh, dram_reset_cfg} <= 2'(i);
			repeat (3) @(posedge clk);
			chk(dram_reset_n, i != 0);
		end
	endtask : t_reset
	initial begin
		repeat (10) @(posedge clk);
		chk(dram_reset_n, 1'b0);
		rst <= 1'b0;
		t_cmds();
		t_write();
		t_read();
		t_fill();
		t_perr();
		t_reset();
		complete_run();
	end
endmodule : ddrpi_channel_test
